// ==== hw/aux_io_function_config.sv ====
// Auxiliary line function select, general-purpose lines and config over serial port
module aux_io_function_config #(
  parameter int unsigned APPLY_CYCLES = aux_io_pkg::FUNC_APPLY_CYCLES,
  parameter int unsigned INT_TICK_CYCLES = aux_io_pkg::INTERNAL_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic [3:0] aux_line_in,
  output logic [3:0] aux_line_out,
  output logic [3:0] aux_line_oe,
  input wire logic data_valid,
  input wire logic [15:0] sync_scale,
  output logic sample_tick,
  output logic ext_clock_active,
  output logic func_write_pending,
  output logic linear_g_comp_en,
  output logic point_of_percussion_en
);

  // True when a two-bit line select names line idx
  function automatic logic line_hit(input logic [1:0] sel, input int unsigned idx);
    line_hit = (sel == idx[1:0]);
  endfunction

  // Clears the external clock enable when it shares the data-ready line
  function automatic logic [15:0] resolve(input logic [15:0] v);
    logic [15:0] r;
    r = v;
    r[15:aux_io_pkg::FN_WIDTH] = '0;
    if (v[aux_io_pkg::FN_DR_EN] && v[aux_io_pkg::FN_SYNC_EN]
        && v[aux_io_pkg::FN_SYNC_SEL +: 2] == v[aux_io_pkg::FN_DR_SEL +: 2]) begin
      r[aux_io_pkg::FN_SYNC_EN] = 1'b0;
    end
    resolve = r;
  endfunction

  // Pin synchronisers: {aux lines, mosi, sclk, cs_n}
  logic [6:0] pin_s1_q, pin_s2_q;
  logic sclk_prev_q, cs_prev_q;
  logic cs_s, sclk_s, mosi_s;
  logic [3:0] aux_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 7'h03;
      pin_s2_q <= 7'h03;
      sclk_prev_q <= 1'b1;
      cs_prev_q <= 1'b1;
    end else begin
      pin_s1_q <= {aux_line_in, mosi, sclk, cs_n};
      pin_s2_q <= pin_s1_q;
      sclk_prev_q <= pin_s2_q[1];
      cs_prev_q <= pin_s2_q[0];
    end
  end

  assign cs_s = pin_s2_q[0];
  assign sclk_s = pin_s2_q[1];
  assign mosi_s = pin_s2_q[2];
  assign aux_s = pin_s2_q[6:3];

  // Serial and register state
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [15:0] rx_q, rx_d;
  logic [15:0] tx_q, tx_d;
  logic [15:0] rsp_q, rsp_d;
  logic miso_q, miso_d;
  logic miso_oe_q, miso_oe_d;
  logic [7:0] page_q, page_d;
  logic [15:0] func_q, func_d;
  logic [15:0] pend_val_q, pend_val_d;
  logic pend_q, pend_d;
  logic [31:0] apply_cnt_q, apply_cnt_d;
  logic [3:0] gp_dir_q, gp_dir_d;
  logic [3:0] gp_lvl_q, gp_lvl_d;
  logic lin_g_q, lin_g_d;
  logic pop_q, pop_d;

  logic sclk_rise, sclk_fall, cs_fall, cs_act;
  logic [15:0] rx_word, pend_base, rd_val;
  logic [6:0] rx_addr;
  logic [7:0] rx_data;
  logic [3:0] gp_read;

  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;
  assign cs_fall = ~cs_s & cs_prev_q;
  assign cs_act = ~cs_s;
  assign rx_word = {rx_q[14:0], mosi_s};
  assign rx_addr = rx_word[aux_io_pkg::ADDR_LSB +: 7];
  assign rx_data = rx_word[7:0];
  assign pend_base = pend_q ? pend_val_q : func_q;

  // Data level readback: live pin for inputs, stored level for outputs
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gp_read[i] = gp_dir_q[i] ? gp_lvl_q[i] : aux_s[i];
    end
  end

  // Read mux on the byte address pair; odd byte reads the same word
  always_comb begin
    rd_val = 16'h0000;
    if ({rx_addr[6:1], 1'b0} == aux_io_pkg::ADDR_PAGE) begin
      rd_val = {8'h00, page_q};
    end else if (page_q == aux_io_pkg::PAGE_THIS) begin
      unique case ({rx_addr[6:1], 1'b0})
        aux_io_pkg::ADDR_FUNC_LO: rd_val = func_q;
        aux_io_pkg::ADDR_GPIO_LO: rd_val = {8'h00, gp_read, gp_dir_q};
        aux_io_pkg::ADDR_CONFIG_LO: rd_val = {8'h00, lin_g_q, pop_q, 6'h00};
        default: rd_val = 16'h0000;
      endcase
    end
  end

  // Serial word engine, register writes and delayed function commit
  always_comb begin
    bit_cnt_d = bit_cnt_q;
    rx_d = rx_q;
    tx_d = tx_q;
    rsp_d = rsp_q;
    miso_d = miso_q;
    miso_oe_d = cs_act;
    page_d = page_q;
    func_d = func_q;
    pend_val_d = pend_val_q;
    pend_d = pend_q;
    apply_cnt_d = apply_cnt_q;
    gp_dir_d = gp_dir_q;
    gp_lvl_d = gp_lvl_q;
    lin_g_d = lin_g_q;
    pop_d = pop_q;

    // Commit a pending function write once the settle time has run out
    if (pend_q) begin
      if (apply_cnt_q >= APPLY_CYCLES - 1) begin
        func_d = resolve(pend_val_q);
        pend_d = 1'b0;
        apply_cnt_d = '0;
      end else begin
        apply_cnt_d = apply_cnt_q + 32'h0000_0001;
      end
    end

    if (!cs_act) begin
      bit_cnt_d = '0;
    end else begin
      if (cs_fall) begin
        tx_d = rsp_q;
      end
      if (sclk_fall) begin
        miso_d = tx_q[15];
        tx_d = {tx_q[14:0], 1'b0};
      end
      if (sclk_rise) begin
        rx_d = rx_word;
        bit_cnt_d = bit_cnt_q + 4'h1;
        if (bit_cnt_q == 4'hf) begin
          rsp_d = 16'h0000;
          if (rx_word[aux_io_pkg::WR_FLAG_BIT]) begin
            if (rx_addr == aux_io_pkg::ADDR_PAGE) begin
              page_d = rx_data;
            end else if (page_q == aux_io_pkg::PAGE_THIS) begin
              unique case (rx_addr)
                aux_io_pkg::ADDR_FUNC_LO: begin
                  pend_val_d = {pend_base[15:8], rx_data};
                  pend_d = 1'b1;
                  apply_cnt_d = '0;
                end
                aux_io_pkg::ADDR_FUNC_HI: begin
                  pend_val_d = {rx_data, pend_base[7:0]};
                  pend_d = 1'b1;
                  apply_cnt_d = '0;
                end
                aux_io_pkg::ADDR_GPIO_LO: begin
                  gp_dir_d = rx_data[aux_io_pkg::GP_DIR +: 4];
                  gp_lvl_d = rx_data[aux_io_pkg::GP_LVL +: 4];
                end
                aux_io_pkg::ADDR_CONFIG_LO: begin
                  lin_g_d = rx_data[aux_io_pkg::CFG_LIN_G];
                  pop_d = rx_data[aux_io_pkg::CFG_POP];
                end
                default: begin
                end
              endcase
            end
          end else begin
            rsp_d = rd_val;
          end
          tx_d = rsp_d;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= '0;
      rx_q <= 16'h0000;
      tx_q <= 16'h0000;
      rsp_q <= 16'h0000;
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
      page_q <= aux_io_pkg::PAGE_RESET;
      func_q <= aux_io_pkg::FUNC_RESET;
      pend_val_q <= aux_io_pkg::FUNC_RESET;
      pend_q <= 1'b0;
      apply_cnt_q <= '0;
      gp_dir_q <= aux_io_pkg::GP_DIR_RESET;
      gp_lvl_q <= aux_io_pkg::GP_LVL_RESET;
      lin_g_q <= aux_io_pkg::CONFIG_RESET[aux_io_pkg::CFG_LIN_G];
      pop_q <= aux_io_pkg::CONFIG_RESET[aux_io_pkg::CFG_POP];
    end else begin
      bit_cnt_q <= bit_cnt_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      rsp_q <= rsp_d;
      miso_q <= miso_d;
      miso_oe_q <= miso_oe_d;
      page_q <= page_d;
      func_q <= func_d;
      pend_val_q <= pend_val_d;
      pend_q <= pend_d;
      apply_cnt_q <= apply_cnt_d;
      gp_dir_q <= gp_dir_d;
      gp_lvl_q <= gp_lvl_d;
      lin_g_q <= lin_g_d;
      pop_q <= pop_d;
    end
  end

  // Decoded functions of the committed register
  logic dr_en, dr_pos, sync_en;
  logic [1:0] dr_sel, sync_sel;
  logic dr_level;

  assign dr_en = func_q[aux_io_pkg::FN_DR_EN];
  assign dr_pos = func_q[aux_io_pkg::FN_DR_POS];
  assign dr_sel = func_q[aux_io_pkg::FN_DR_SEL +: 2];
  assign sync_en = func_q[aux_io_pkg::FN_SYNC_EN];
  assign sync_sel = func_q[aux_io_pkg::FN_SYNC_SEL +: 2];
  assign dr_level = dr_pos ? data_valid : ~data_valid;

  // Per-line routing by priority
  logic [3:0] line_out_q, line_out_d;
  logic [3:0] line_oe_q, line_oe_d;

  for (genvar g = 0; g < 4; g++) begin : g_line
    always_comb begin
      if (dr_en && line_hit(dr_sel, g)) begin
        line_out_d[g] = dr_level;
        line_oe_d[g] = 1'b1;
      end else if (sync_en && line_hit(sync_sel, g)) begin
        line_out_d[g] = 1'b0;
        line_oe_d[g] = 1'b0;
      end else begin
        line_out_d[g] = gp_lvl_q[g];
        line_oe_d[g] = gp_dir_q[g];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_out_q <= 4'h0;
      line_oe_q <= 4'h0;
    end else begin
      line_out_q <= line_out_d;
      line_oe_q <= line_oe_d;
    end
  end

  // External clock routing into the rate generator
  ext_clock_if ext_if ();

  assign ext_if.level = aux_s[sync_sel];
  assign ext_if.enable = sync_en;
  assign ext_if.rising = func_q[aux_io_pkg::FN_SYNC_RISE];
  assign ext_if.pps_mode = func_q[aux_io_pkg::FN_PPS];
  assign ext_if.scale = sync_scale;

  sync_edge_rate u_rate (
    .clk(clk),
    .rst_n(rst_n),
    .ext(ext_if.rate)
  );

  // Internal sample clock, held stopped while an external clock is in use
  logic [31:0] int_cnt_q, int_cnt_d;
  logic tick_q, tick_d;

  always_comb begin
    int_cnt_d = int_cnt_q;
    tick_d = 1'b0;
    if (sync_en) begin
      int_cnt_d = '0;
      tick_d = ext_if.tick;
    end else if (int_cnt_q >= INT_TICK_CYCLES - 1) begin
      int_cnt_d = '0;
      tick_d = 1'b1;
    end else begin
      int_cnt_d = int_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      int_cnt_q <= int_cnt_d;
      tick_q <= tick_d;
    end
  end

  // Status flags mirrored to outputs
  logic ext_act_q, pend_out_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_act_q <= 1'b0;
      pend_out_q <= 1'b0;
    end else begin
      ext_act_q <= sync_en;
      pend_out_q <= pend_q;
    end
  end

  assign miso = miso_q;
  assign miso_oe = miso_oe_q;
  assign aux_line_out = line_out_q;
  assign aux_line_oe = line_oe_q;
  assign sample_tick = tick_q;
  assign ext_clock_active = ext_act_q;
  assign func_write_pending = pend_out_q;
  assign linear_g_comp_en = lin_g_q;
  assign point_of_percussion_en = pop_q;

endmodule // aux_io_function_config

// ==== inc/aux_io_pkg.sv ====
package aux_io_pkg;

  // Serial word layout
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned WR_FLAG_BIT = 15;
  localparam int unsigned ADDR_LSB = 8;

  // Register byte addresses on the selected page
  localparam logic [6:0] ADDR_PAGE = 7'h00;
  localparam logic [6:0] ADDR_FUNC_LO = 7'h06;
  localparam logic [6:0] ADDR_FUNC_HI = 7'h07;
  localparam logic [6:0] ADDR_GPIO_LO = 7'h08;
  localparam logic [6:0] ADDR_GPIO_HI = 7'h09;
  localparam logic [6:0] ADDR_CONFIG_LO = 7'h0a;
  localparam logic [6:0] ADDR_CONFIG_HI = 7'h0b;
  localparam logic [7:0] PAGE_THIS = 8'h03;
  localparam logic [7:0] PAGE_RESET = 8'h00;

  // Function register fields
  localparam int unsigned FN_PPS = 8;
  localparam int unsigned FN_SYNC_EN = 7;
  localparam int unsigned FN_SYNC_RISE = 6;
  localparam int unsigned FN_SYNC_SEL = 4;
  localparam int unsigned FN_DR_EN = 3;
  localparam int unsigned FN_DR_POS = 2;
  localparam int unsigned FN_DR_SEL = 0;
  localparam int unsigned FN_WIDTH = 9;
  localparam logic [15:0] FUNC_RESET = 16'h000d;

  // General-purpose register fields
  localparam int unsigned GP_DIR = 0;
  localparam int unsigned GP_LVL = 4;
  localparam logic [3:0] GP_DIR_RESET = 4'h0;
  localparam logic [3:0] GP_LVL_RESET = 4'h0;

  // Config register fields
  localparam int unsigned CFG_POP = 6;
  localparam int unsigned CFG_LIN_G = 7;
  localparam logic [15:0] CONFIG_RESET = 16'h00c0;

  // Timing
  localparam int unsigned CLK_HZ = 32'h05f5_e100;
  localparam int unsigned FUNC_APPLY_MS = 32'h0000_0014;
  localparam int unsigned FUNC_APPLY_CYCLES = CLK_HZ / 32'h0000_03e8 * FUNC_APPLY_MS;
  localparam int unsigned INTERNAL_RATE_HZ = 32'h0000_109a;
  localparam int unsigned INTERNAL_TICK_CYCLES = CLK_HZ / INTERNAL_RATE_HZ;
  localparam int unsigned PERIOD_W = 28;

endpackage

// ==== inc/ext_clock_if.sv ====
// External sample clock link between line routing and rate generator
interface ext_clock_if;
  logic level;
  logic enable;
  logic rising;
  logic pps_mode;
  logic [15:0] scale;
  logic tick;

  modport cfg (output level, output enable, output rising, output pps_mode, output scale, input tick);
  modport rate (input level, input enable, input rising, input pps_mode, input scale, output tick);
endinterface

// ==== hw/sync_edge_rate.sv ====
// Turns the routed external clock into processing-rate ticks
module sync_edge_rate (
  input wire logic clk,
  input wire logic rst_n,
  ext_clock_if.rate ext
);

  logic prev_q, prev_d;
  logic [aux_io_pkg::PERIOD_W-1:0] cnt_q, cnt_d;
  logic [aux_io_pkg::PERIOD_W-1:0] period_q, period_d;
  logic [aux_io_pkg::PERIOD_W:0] acc_q, acc_d;
  logic tick_q, tick_d;
  logic edge_hit;
  logic [aux_io_pkg::PERIOD_W:0] sum;

  // Active edge detect on the already synchronised level
  assign edge_hit = ext.enable & (ext.rising ? (ext.level & ~prev_q) : (~ext.level & prev_q));

  // Period measurement and scaled tick accumulator
  always_comb begin
    prev_d = ext.level;
    cnt_d = cnt_q;
    period_d = period_q;
    acc_d = acc_q;
    tick_d = 1'b0;
    sum = acc_q + {13'h0000, ext.scale};
    if (!ext.enable) begin
      cnt_d = '0;
      period_d = '0;
      acc_d = '0;
    end else begin
      if (cnt_q != '1) begin
        cnt_d = cnt_q + 1'b1;
      end
      if (edge_hit) begin
        period_d = cnt_q + 1'b1;
        cnt_d = '0;
      end
      if (!ext.pps_mode) begin
        tick_d = edge_hit;
      end else if (edge_hit) begin
        acc_d = '0; // Realign phase on each pulse
        tick_d = (period_q != '0);
      end else if (period_q != '0) begin
        if (sum >= {1'b0, period_q}) begin
          acc_d = sum - {1'b0, period_q};
          tick_d = 1'b1;
        end else begin
          acc_d = sum;
        end
      end
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
      cnt_q <= '0;
      period_q <= '0;
      acc_q <= '0;
      tick_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      cnt_q <= cnt_d;
      period_q <= period_d;
      acc_q <= acc_d;
      tick_q <= tick_d;
    end
  end

  assign ext.tick = tick_q;

endmodule // sync_edge_rate

// ==== sim/aux_io_function_config_assertions.sv ====
module aux_io_function_config_checker #(
  parameter int unsigned APPLY_CYCLES = aux_io_pkg::FUNC_APPLY_CYCLES,
  parameter int unsigned INT_TICK_CYCLES = aux_io_pkg::INTERNAL_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic [3:0] aux_line_in,
  input wire logic [3:0] aux_line_out,
  input wire logic [3:0] aux_line_oe,
  input wire logic data_valid,
  input wire logic [15:0] sync_scale,
  input wire logic sample_tick,
  input wire logic ext_clock_active,
  input wire logic func_write_pending,
  input wire logic linear_g_comp_en,
  input wire logic point_of_percussion_en
);
  logic [31:0] gap_q, gap_d;
  logic clean_q, clean_d;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Cycles since last tick, and whether the internal clock ran all along
  always_comb begin
    gap_d = sample_tick ? 32'h0000_0001 : gap_q + 32'h0000_0001;
    clean_d = sample_tick ? !ext_clock_active : (clean_q && !ext_clock_active);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 32'h0000_0000;
      clean_q <= 1'b0;
    end else begin
      gap_q <= gap_d;
      clean_q <= clean_d;
    end
  end

  a_reset_drdy_oe: assert property (!$past(rst_n) |=> aux_line_oe == 4'b0010)
    else $error("data-ready line not driven after reset");
  a_reset_drdy_out: assert property (!$past(rst_n) |=> (aux_line_out[1] == $past(data_valid)) [*4])
    else $error("data-ready line does not follow data valid");
  a_reset_cfg_bits: assert property (!$past(rst_n) |-> linear_g_comp_en && point_of_percussion_en)
    else $error("config bits wrong after reset");
  a_pending_hold_state: assert property (func_write_pending && $past(func_write_pending) |-> $stable(ext_clock_active))
    else $error("state changed while function write pending");
  a_ext_change_commit: assert property ($changed(ext_clock_active) |-> $fell(func_write_pending))
    else $error("external clock changed outside a commit");
  a_int_tick_rate: assert property (sample_tick && clean_q && !ext_clock_active |-> gap_q == INT_TICK_CYCLES)
    else $error("internal tick spacing wrong");
  a_tick_single_pulse: assert property (sample_tick && !ext_clock_active |=> !sample_tick)
    else $error("internal tick longer than one cycle");
  a_cfg_serial_only: assert property ($changed(linear_g_comp_en) || $changed(point_of_percussion_en) |-> !$past(cs_n))
    else $error("config changed without serial access");
endmodule // aux_io_function_config_checker

bind aux_io_function_config aux_io_function_config_checker #(
  .APPLY_CYCLES(APPLY_CYCLES), .INT_TICK_CYCLES(INT_TICK_CYCLES)) i_aux_io_function_config_checker (
  .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
  .aux_line_in(aux_line_in), .aux_line_out(aux_line_out), .aux_line_oe(aux_line_oe),
  .data_valid(data_valid), .sync_scale(sync_scale), .sample_tick(sample_tick),
  .ext_clock_active(ext_clock_active), .func_write_pending(func_write_pending),
  .linear_g_comp_en(linear_g_comp_en), .point_of_percussion_en(point_of_percussion_en));

// ==== sim/spi_host_model.sv ====
module spi_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 6;

  // Idle bus: deselected, clock high
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    mosi = 1'b0;
  end

  // One 16-bit word per frame, bit 15 first; returns what the device shifted out
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk) #1 cs_n = 1'b0;
    repeat (HALF) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      #1 sclk = 1'b0;
      mosi = tx[i];
      repeat (HALF) @(posedge clk);
      rx[i] = miso & miso_oe;
      #1 sclk = 1'b1;
      repeat (HALF) @(posedge clk);
    end
    #1 cs_n = 1'b1;
    mosi = ~mosi;
    repeat (HALF) @(posedge clk);
  endtask
endmodule // spi_host_model

// ==== sim/test_aux_io_function_config.sv ====
module test_aux_io_function_config;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned APPLY = 1500;
  localparam int LIMIT = 60000;
  typedef struct packed {
    logic [15:0] func;
    logic [15:0] gpio;
    logic [3:0] oe;
    logic [3:0] out;
    logic [15:0] rb;
    logic ext;
  } row_t;
  logic clk, rst_n, cs_n, sclk, mosi, miso, miso_oe, data_valid, sample_tick;
  logic ext_clock_active, func_write_pending, linear_g_comp_en, point_of_percussion_en;
  logic [3:0] aux_line_in, aux_line_out, aux_line_oe, pin_drv;
  logic [15:0] sync_scale, rd_v, prev_rb;
  int n_mismatch = 0;
  int checks_done = 0;
  int ticks = 0;
  int cycles = 0;
  int t0;
  // Function, gpio, expected oe, driven levels, readback, external clock
  row_t rows [6] = '{
    '{16'h000d, 16'h00ff, 4'hf, 4'hd, 16'h000d, 1'b0},
    '{16'h0088, 16'h00ff, 4'hf, 4'hf, 16'h0008, 1'b0},
    '{16'h00fd, 16'h00ff, 4'h7, 4'h5, 16'h00fd, 1'b1},
    '{16'h00dd, 16'h00ff, 4'hf, 4'hd, 16'h005d, 1'b0},
    '{16'h000a, 16'h0055, 4'h5, 4'h5, 16'h000a, 1'b0},
    '{16'h01af, 16'h00ff, 4'hb, 4'h3, 16'h01af, 1'b1}};

  // Wire level: device drives where enabled, bench elsewhere
  assign aux_line_in = (aux_line_oe & aux_line_out) | (~aux_line_oe & pin_drv);

  aux_io_function_config #(.APPLY_CYCLES(APPLY), .INT_TICK_CYCLES(20)) i_aux_io_function_config (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .aux_line_in(aux_line_in), .aux_line_out(aux_line_out), .aux_line_oe(aux_line_oe),
    .data_valid(data_valid), .sync_scale(sync_scale), .sample_tick(sample_tick),
    .ext_clock_active(ext_clock_active), .func_write_pending(func_write_pending),
    .linear_g_comp_en(linear_g_comp_en), .point_of_percussion_en(point_of_percussion_en));

  spi_host_model i_spi_host_model (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Tick counting and hang guard
  always @(posedge clk) begin
    if (sample_tick === 1'b1) ticks <= ticks + 1;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch = n_mismatch + 1;
      test_done();
    end
  end

  task automatic test_done();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: register read %h, want %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: pins %b, want %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    i_spi_host_model.xfer({1'b1, a, d}, r);
  endtask

  // Low byte word first, then high byte word
  task automatic wr16(input logic [6:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 7'h01, v[15:8]);
  endtask

  // Answer arrives during the following word
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    logic [15:0] r;
    i_spi_host_model.xfer({1'b0, a, 8'h00}, r);
    i_spi_host_model.xfer(16'h0000, v);
  endtask

  // Output lines read back stored level, input lines the wire
  function automatic logic [15:0] exp_gpio(input logic [15:0] g);
    logic [3:0] l;
    for (int i = 0; i < 4; i++) l[i] = g[i] ? g[4 + i] : pin_drv[i];
    return {8'h00, l, g[3:0]};
  endfunction

  initial begin
    rst_n = 1'b0;
    data_valid = 1'b1;
    pin_drv = 4'h0;
    sync_scale = 16'h0004;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1 data_valid = 1'b0;
    repeat (4) @(posedge clk);
    chk_pin(aux_line_oe, 4'h2);
    chk_pin({2'b00, linear_g_comp_en, point_of_percussion_en}, 4'h3);
    wr16(7'h0a, 16'h0000);
    wr(7'h00, 8'h03);
    rd(7'h06, rd_v);
    chk_reg(rd_v, 16'h000d);
    rd(7'h0a, rd_v);
    chk_reg(rd_v, 16'h00c0);
    rd(7'h20, rd_v);
    chk_reg(rd_v, 16'h0000);
    wr16(7'h0a, 16'h0040);
    chk_pin({2'b00, linear_g_comp_en, point_of_percussion_en}, 4'h1);
    wr16(7'h0a, 16'h0080);
    chk_pin({2'b00, linear_g_comp_en, point_of_percussion_en}, 4'h2);
    // Function table, starting from line 2 data-ready as set at start-up
    prev_rb = 16'h000d;
    foreach (rows[i]) begin
      wr16(7'h08, rows[i].gpio);
      wr16(7'h06, rows[i].func);
      chk_pin({3'b000, func_write_pending}, 4'h1);
      rd(7'h06, rd_v);
      chk_reg(rd_v, prev_rb);
      rd(7'h08, rd_v);
      chk_reg(rd_v, exp_gpio(rows[i].gpio));
      repeat (APPLY + 10) @(posedge clk);
      chk_pin(aux_line_oe, rows[i].oe);
      chk_pin(aux_line_out & aux_line_oe, rows[i].out);
      chk_pin({3'b000, ext_clock_active}, {3'b000, rows[i].ext});
      rd(7'h06, rd_v);
      chk_reg(rd_v, rows[i].rb);
      rd(7'h08, rd_v);
      chk_reg(rd_v, exp_gpio(rows[i].gpio));
      prev_rb = rows[i].rb;
    end
    // Direct sync on line 4, rising edges only
    wr16(7'h06, 16'h00fd);
    repeat (APPLY + 10) @(posedge clk);
    t0 = ticks;
    repeat (100) @(posedge clk);
    chk_pin(4'(ticks - t0), 4'h0);
    t0 = ticks;
    repeat (3) begin
      #1 pin_drv[3] = 1'b1;
      repeat (15) @(posedge clk);
      #1 pin_drv[3] = 1'b0;
      repeat (15) @(posedge clk);
    end
    chk_pin(4'(ticks - t0), 4'h3);
    // Direct sync on line 4, falling edges only
    wr16(7'h06, 16'h00bd);
    repeat (APPLY + 10) @(posedge clk);
    t0 = ticks;
    #1 pin_drv[3] = 1'b1;
    repeat (15) @(posedge clk);
    chk_pin(4'(ticks - t0), 4'h0);
    #1 pin_drv[3] = 1'b0;
    repeat (15) @(posedge clk);
    chk_pin(4'(ticks - t0), 4'h1);
    // Scaled mode: about four ticks per external period
    wr16(7'h06, 16'h01fd);
    repeat (APPLY + 10) @(posedge clk);
    for (int k = 0; k < 6; k++) begin
      if (k == 3) t0 = ticks;
      #1 pin_drv[3] = 1'b1;
      repeat (50) @(posedge clk);
      #1 pin_drv[3] = 1'b0;
      repeat (50) @(posedge clk);
    end
    chk_pin({3'b000, (ticks - t0 >= 11) && (ticks - t0 <= 13)}, 4'h1);
    // Second reset in mid-run
    #1 rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge clk);
    chk_pin(aux_line_oe, 4'h2);
    wr(7'h00, 8'h03);
    rd(7'h06, rd_v);
    chk_reg(rd_v, 16'h000d);
    test_done();
  end
endmodule // test_aux_io_function_config
